/* pdc_power_down.sv */
// Power-down entry/exit and command admission for one DRAM channel.
// Assumes CKE, CS and decoded commands are synchronous to clk_sys_i.
//
// Summary of operation
// (R1) MRR, MPC, MRW accepted during self-refresh exit
// (R2) MRR, MRW, MPC executed while refresh runs
// (R3) CKE low enters, CKE high leaves power-down
// (R4) Controller keeps CKE high during busy operations
// (R5) Array operations finish; low current afterwards
// (R6) Controller holds CS low, clock running
// (R7) Receivers off after tCKELCK, inputs ignored
// (R8) Controller holds CKE low for tCKE
// (R9) No refresh in power-down except self-refresh
// (R10) Controller holds CKE high, waits tXP
// (R11) Controller keeps clock steady in guarded intervals
// (R12) Variant classified at entry: idle, active, self
// (R13) Command-bus termination stays on in power-down
// (R14) Controller avoids power-down during oscillator run
// (R15) Controller spaces read to CKE fall
// (R16) Controller spaces write to CKE fall
// (R17) Controller spaces auto-precharge write to CKE fall
// (R18) Controller waits tCMDCKE after refresh, activate, precharge
// (R19) Controller waits tMRWCKEL after mode write
// (R20) ZQ calibration continues if CKE fell late
// (R21) Controller gives stable clock before CKE rises
// (R22) Controller counts intervals in whole cycles
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module pdc_power_down (
   input  wire logic                 clk_sys_i,     // Core clock, 50 MHz
   input  wire logic                 reset_i,       // Synchronous reset, active high
   input  wire logic                 cke_i,         // Clock enable pin
   input  wire logic                 vddq_ok_i,     // I/O supply within range
   input  wire logic                 array_busy_i,  // Row activate/precharge running
   input  wire logic                 cmd_valid_i,   // Decoded command present
   input  wire pdc_pkg::pdc_cmd_type cmd_i,         // Decoded command
   input  wire logic [3:0]           addr_i,        // Register byte address
   input  wire logic [31:0]          wdata_i,       // Register write data
   input  wire logic                 we_i,          // Register write strobe
   input  wire logic                 re_i,          // Register read strobe
   output logic [31:0]               rdata_o,       // Register read data, next cycle
   output logic                      cmd_exec_o,    // Command accepted, one cycle
   output pdc_pkg::pdc_cmd_type      cmd_exec_cmd_o, // Accepted command
   output logic                      cmd_reject_o,  // Command refused, one cycle
   output logic                      rx_enable_o,   // Input receivers and buffers on
   output logic                      power_down_o,  // In power-down
   output logic                      low_power_o,   // Reduced current applies
   output pdc_pkg::pdc_pd_kind_type  pd_kind_o,     // Variant of current power-down
   output logic                      sr_refresh_o,  // Internal refresh pulse
   output logic                      zq_busy_o,     // ZQ calibration running
   output logic                      ca_odt_o       // Command-bus termination on
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State

   pdc_pkg::pdc_state_type   state_r, state_nxt;
   pdc_pkg::pdc_pd_kind_type kind_r, kind_nxt;
   logic [15:0] pd_cnt_r, pd_cnt_nxt;      // tCKELCK then tXP
   logic [15:0] xsr_cnt_r, xsr_cnt_nxt;    // Self-refresh exit window
   logic [15:0] rfc_cnt_r, rfc_cnt_nxt;    // Refresh cycle window
   logic [15:0] zq_cnt_r, zq_cnt_nxt;      // Calibration run time
   logic [15:0] zqcke_cnt_r, zqcke_cnt_nxt; // ZQ start to safe CKE fall
   logic [15:0] srefi_cnt_r, srefi_cnt_nxt; // Internal refresh timer
   logic        sr_active_r, sr_active_nxt;
   logic [7:0]  bank_open_r, bank_open_nxt;
   logic [2:0]  odt_code_r, odt_code_nxt;
   logic        exec_r, exec_nxt;
   logic        reject_r, reject_nxt;
   logic        srref_r, srref_nxt;
   pdc_pkg::pdc_cmd_type cmd_r, cmd_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   logic cmd_ok;    // Command admissible in present state
   logic mode_cmd;  // MRR, MRW, MPC or ZQS family

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Command admission

   // Self-refresh exit only lets the mode family through, and not every MRW
   always_comb begin
      mode_cmd = (cmd_i.kind == pdc_pkg::CMD_MRR) || (cmd_i.kind == pdc_pkg::CMD_MRW) ||
                 (cmd_i.kind == pdc_pkg::CMD_MPC) || (cmd_i.kind == pdc_pkg::CMD_ZQS);
      cmd_ok = (state_r == pdc_pkg::PS_AWAKE);              // see (R7) (R10)
      if (xsr_cnt_r != 16'h0000) begin
         cmd_ok = cmd_ok && mode_cmd;                       // see (R1)
         if (cmd_i.kind == pdc_pkg::CMD_MRW &&
             (cmd_i.mr_addr == pdc_pkg::MRA_PASR_BANK ||
              cmd_i.mr_addr == pdc_pkg::MRA_PASR_SEG ||
              cmd_i.mr_addr == pdc_pkg::MRA_SR_ABORT)) begin
            cmd_ok = 1'b0;                                  // see (R1)
         end
      end
      // A running refresh blocks nothing in the mode family
      if (rfc_cnt_r != 16'h0000 && !mode_cmd &&
          (cmd_i.kind == pdc_pkg::CMD_REFAB || cmd_i.kind == pdc_pkg::CMD_REFPB)) begin
         cmd_ok = 1'b0;                                     // see (R2)
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Power state, windows and bank tracking

   // CKE is watched every cycle; entry and exit need no command
   always_comb begin
      state_nxt     = state_r;
      kind_nxt      = kind_r;
      pd_cnt_nxt    = (pd_cnt_r != 16'h0000) ? pd_cnt_r - 16'h0001 : 16'h0000;
      xsr_cnt_nxt   = (xsr_cnt_r != 16'h0000) ? xsr_cnt_r - 16'h0001 : 16'h0000;
      rfc_cnt_nxt   = (rfc_cnt_r != 16'h0000) ? rfc_cnt_r - 16'h0001 : 16'h0000;
      zq_cnt_nxt    = (zq_cnt_r != 16'h0000) ? zq_cnt_r - 16'h0001 : 16'h0000;
      zqcke_cnt_nxt = (zqcke_cnt_r != 16'h0000) ? zqcke_cnt_r - 16'h0001 : 16'h0000;
      srefi_cnt_nxt = srefi_cnt_r;
      sr_active_nxt = sr_active_r;
      bank_open_nxt = bank_open_r;
      exec_nxt      = 1'b0;
      reject_nxt    = 1'b0;
      srref_nxt     = 1'b0;
      cmd_nxt       = cmd_r;

      unique case (state_r)
         pdc_pkg::PS_AWAKE: begin
            if (!cke_i) begin
               state_nxt  = pdc_pkg::PS_ENTRY;              // see (R3)
               pd_cnt_nxt = pdc_pkg::CKELCK_CYC;
               // Variant is frozen from the state at the moment of entry
               if (sr_active_r) begin
                  kind_nxt = pdc_pkg::PD_SELF;              // see (R12)
               end else if (bank_open_r != 8'h00) begin
                  kind_nxt = pdc_pkg::PD_ACTIVE;            // see (R12)
               end else begin
                  kind_nxt = pdc_pkg::PD_IDLE;              // see (R12)
               end
               // Calibration started too recently is dropped
               if (zqcke_cnt_r != 16'h0000) begin
                  zq_cnt_nxt = 16'h0000;                    // see (R20)
               end
            end
         end
         pdc_pkg::PS_ENTRY: begin
            if (cke_i) begin
               state_nxt  = pdc_pkg::PS_EXIT;               // see (R3)
               pd_cnt_nxt = pdc_pkg::XP_CYC;
            end else if (pd_cnt_r <= 16'h0001) begin
               state_nxt = pdc_pkg::PS_DOWN;                // see (R7)
            end
         end
         pdc_pkg::PS_DOWN: begin
            if (cke_i) begin
               state_nxt  = pdc_pkg::PS_EXIT;               // see (R3)
               pd_cnt_nxt = pdc_pkg::XP_CYC;
            end
         end
         pdc_pkg::PS_EXIT: begin
            if (!cke_i) begin
               state_nxt  = pdc_pkg::PS_ENTRY;              // see (R3)
               pd_cnt_nxt = pdc_pkg::CKELCK_CYC;
            end else if (pd_cnt_r <= 16'h0001) begin
               state_nxt = pdc_pkg::PS_AWAKE;               // see (R10)
               kind_nxt  = pdc_pkg::PD_NONE;
            end
         end
      endcase

      // Internal refresh only runs with self refresh active
      if (sr_active_r) begin                                // see (R9) (R12)
         if (srefi_cnt_r <= 16'h0001) begin
            srefi_cnt_nxt = pdc_pkg::SREFI_CYC;
            srref_nxt     = 1'b1;
         end else begin
            srefi_cnt_nxt = srefi_cnt_r - 16'h0001;
         end
      end else begin
         srefi_cnt_nxt = pdc_pkg::SREFI_CYC;
      end

      // Commands on an awake, admissible bus
      if (cmd_valid_i && cmd_i.kind != pdc_pkg::CMD_NOP) begin
         if (cmd_ok) begin
            exec_nxt = 1'b1;
            cmd_nxt  = cmd_i;
            unique case (cmd_i.kind)
               pdc_pkg::CMD_ACT:   bank_open_nxt[cmd_i.bank] = 1'b1;
               pdc_pkg::CMD_PRE:   bank_open_nxt[cmd_i.bank] = 1'b0;
               pdc_pkg::CMD_PREA:  bank_open_nxt = 8'h00;
               pdc_pkg::CMD_RD, pdc_pkg::CMD_WR: begin
                  if (cmd_i.auto_pre) begin
                     bank_open_nxt[cmd_i.bank] = 1'b0;
                  end
               end
               pdc_pkg::CMD_REFAB: rfc_cnt_nxt = pdc_pkg::RFCAB_CYC;  // see (R2)
               pdc_pkg::CMD_REFPB: rfc_cnt_nxt = pdc_pkg::RFCPB_CYC;  // see (R2)
               pdc_pkg::CMD_ZQS: begin
                  zq_cnt_nxt    = pdc_pkg::ZQCAL_CYC;
                  zqcke_cnt_nxt = pdc_pkg::ZQCKE_CYC;
               end
               pdc_pkg::CMD_SRE:   sr_active_nxt = 1'b1;
               pdc_pkg::CMD_SRX: begin
                  sr_active_nxt = 1'b0;
                  xsr_cnt_nxt   = pdc_pkg::XSR_CYC;          // see (R1)
               end
               default: ;
            endcase
         end else begin
            reject_nxt = 1'b1;                              // see (R7)
         end
      end
   end

   // Register the power state group
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r     <= pdc_pkg::PS_AWAKE;
         kind_r      <= pdc_pkg::PD_NONE;
         pd_cnt_r    <= 16'h0000;
         xsr_cnt_r   <= 16'h0000;
         rfc_cnt_r   <= 16'h0000;
         zq_cnt_r    <= 16'h0000;
         zqcke_cnt_r <= 16'h0000;
         srefi_cnt_r <= 16'h0000;
         sr_active_r <= 1'b0;
         bank_open_r <= 8'h00;
         exec_r      <= 1'b0;
         reject_r    <= 1'b0;
         srref_r     <= 1'b0;
         cmd_r       <= '0;
      end else begin
         state_r     <= state_nxt;
         kind_r      <= kind_nxt;
         pd_cnt_r    <= pd_cnt_nxt;
         xsr_cnt_r   <= xsr_cnt_nxt;
         rfc_cnt_r   <= rfc_cnt_nxt;
         zq_cnt_r    <= zq_cnt_nxt;
         zqcke_cnt_r <= zqcke_cnt_nxt;
         srefi_cnt_r <= srefi_cnt_nxt;
         sr_active_r <= sr_active_nxt;
         bank_open_r <= bank_open_nxt;
         exec_r      <= exec_nxt;
         reject_r    <= reject_nxt;
         srref_r     <= srref_nxt;
         cmd_r       <= cmd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register port

   // Unmapped addresses read zero and ignore writes
   always_comb begin
      odt_code_nxt = odt_code_r;
      rdata_nxt    = 32'h0000_0000;
      if (we_i && addr_i == pdc_pkg::REG_CTRL) begin
         odt_code_nxt = wdata_i[pdc_pkg::CTRL_ODT_MSB:pdc_pkg::CTRL_ODT_LSB];
      end
      if (re_i) begin
         unique case (addr_i)
            pdc_pkg::REG_CTRL:
               rdata_nxt[pdc_pkg::CTRL_ODT_MSB:pdc_pkg::CTRL_ODT_LSB] = odt_code_r;
            pdc_pkg::REG_STATUS:
               rdata_nxt = {12'h000, bank_open_r, 3'h0, zq_busy_o, rfc_cnt_r != 16'h0000,
                            xsr_cnt_r != 16'h0000, sr_active_r, rx_enable_o, kind_r, state_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Register the port group
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         odt_code_r <= pdc_pkg::CTRL_ODT_RST;
         rdata_r    <= 32'h0000_0000;
      end else begin
         odt_code_r <= odt_code_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Receivers stay on through tCKELCK so late CS samples are still seen
   assign rx_enable_o    = (state_r != pdc_pkg::PS_DOWN);   // see (R7)
   assign power_down_o   = (state_r != pdc_pkg::PS_AWAKE);  // see (R3)
   // Reduced current waits for in-flight array work to finish
   assign low_power_o    = (state_r == pdc_pkg::PS_DOWN) && !array_busy_i &&
                           (rfc_cnt_r == 16'h0000);         // see (R5)
   assign pd_kind_o      = kind_r;
   assign sr_refresh_o   = srref_r;                         // see (R9)
   assign zq_busy_o      = (zq_cnt_r != 16'h0000);          // see (R20)
   // Termination ignores power state; only a nonzero code and the I/O supply gate it
   assign ca_odt_o       = (odt_code_r != 3'h0) && vddq_ok_i; // see (R13)
   assign cmd_exec_o     = exec_r;
   assign cmd_exec_cmd_o = cmd_r;
   assign cmd_reject_o   = reject_r;
   assign rdata_o        = rdata_r;

endmodule // pdc_power_down

/* pdc_pkg.sv */
// Package for the power-down controller of one low-power DRAM channel.
// Assumes a 50 MHz core clock; commands arrive already decoded.
package pdc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and interval figures
   localparam int CLK_PERIOD_PS = 20000;           // 50 MHz core clock
   localparam int T_CKELCK_NS   = 5;               // Clock kept after CKE falls
   localparam int T_XP_NS       = 8;               // Power-down exit latency
   localparam int T_XSR_NS      = 188;             // Self-refresh exit interval
   localparam int T_RFCAB_NS    = 180;             // All-bank refresh cycle
   localparam int T_RFCPB_NS    = 90;              // Per-bank refresh cycle
   localparam int T_ZQCKE_NS    = 8;               // ZQ start to CKE low
   localparam int T_ZQCAL_NS    = 1000;            // ZQ calibration run time
   localparam int T_SREFI_NS    = 3904;            // Internal self-refresh period

   // Least times round up to whole cycles, never below one
   function automatic logic [15:0] ns2cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (c < 1) begin
         c = 1;
      end
      return c[15:0];
   endfunction

   localparam logic [15:0] CKELCK_CYC = ns2cyc(T_CKELCK_NS);
   localparam logic [15:0] XP_CYC     = ns2cyc(T_XP_NS);
   localparam logic [15:0] XSR_CYC    = ns2cyc(T_XSR_NS);
   localparam logic [15:0] RFCAB_CYC  = ns2cyc(T_RFCAB_NS);
   localparam logic [15:0] RFCPB_CYC  = ns2cyc(T_RFCPB_NS);
   localparam logic [15:0] ZQCKE_CYC  = ns2cyc(T_ZQCKE_NS);
   localparam logic [15:0] ZQCAL_CYC  = ns2cyc(T_ZQCAL_NS);
   localparam logic [15:0] SREFI_CYC  = ns2cyc(T_SREFI_NS);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Mode-register addresses whose writes are refused during self-refresh exit
   localparam logic [5:0] MRA_SR_ABORT  = 6'h04;   // Holds the self-refresh abort bit
   localparam logic [5:0] MRA_PASR_BANK = 6'h10;   // Partial-array bank mask
   localparam logic [5:0] MRA_PASR_SEG  = 6'h11;   // Partial-array segment mask

   // Register map, byte addresses
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_ODT_LSB = 4;                // Command-bus termination code [6:4]
   localparam int CTRL_ODT_MSB = 6;
   localparam logic [2:0] CTRL_ODT_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Decoded command kinds
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_PRE = 4'h2, CMD_PREA = 4'h3,
      CMD_RD  = 4'h4, CMD_WR  = 4'h5, CMD_MRR = 4'h6, CMD_MRW  = 4'h7,
      CMD_MPC = 4'h8, CMD_ZQS = 4'h9, CMD_REFAB = 4'hA, CMD_REFPB = 4'hB,
      CMD_SRE = 4'hC, CMD_SRX = 4'hD
   } pdc_cmd_kind_type;

   typedef struct packed {
      pdc_cmd_kind_type kind;    // Command kind
      logic [2:0]       bank;    // Bank address
      logic             auto_pre; // Auto precharge on read or write
      logic [5:0]       mr_addr; // Mode-register address
   } pdc_cmd_type;

   // Power-down states, Gray along awake -> entry -> down -> exit
   typedef enum logic [1:0] {
      PS_AWAKE = 2'b00, PS_ENTRY = 2'b01, PS_DOWN = 2'b11, PS_EXIT = 2'b10
   } pdc_state_type;

   // Power-down variant fixed at entry
   typedef enum logic [1:0] {
      PD_NONE = 2'h0, PD_IDLE = 2'h1, PD_ACTIVE = 2'h2, PD_SELF = 2'h3
   } pdc_pd_kind_type;

endpackage

/* pdc_power_down_assertions.sv */
// Checker for the power-down block, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module pdc_pd_chk (
   input wire logic                     clk_sys_i,    // Core clock
   input wire logic                     reset_i,      // Sync reset
   input wire logic                     cke_i,        // Clock enable pin
   input wire logic                     vddq_ok_i,    // I/O supply valid
   input wire logic                     array_busy_i, // Array still busy
   input wire logic                     cmd_valid_i,  // Command present
   input wire pdc_pkg::pdc_cmd_type     cmd_i,        // Command
   input wire logic                     we_i,         // Register write
   input wire logic                     cmd_exec_o,   // Accept pulse
   input wire logic                     cmd_reject_o, // Refuse pulse
   input wire logic                     rx_enable_o,  // Receivers on
   input wire logic                     power_down_o, // In power-down
   input wire logic                     low_power_o,  // Low current
   input wire pdc_pkg::pdc_pd_kind_type pd_kind_o,    // Variant
   input wire logic                     sr_refresh_o, // Refresh pulse
   input wire logic                     ca_odt_o      // Termination on
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   // Real request, a NOP is never answered
   logic req;
   assign req = cmd_valid_i && (cmd_i.kind != pdc_pkg::CMD_NOP);

   ////////////////////////////////////////////////////////////////////////
   // Entry and wake-up steps
   sequence s_fall;
      !power_down_o && !cke_i;
   endsequence
   sequence s_wake;
      (!rx_enable_o && cke_i) ##1 cke_i;
   endsequence

   AST_ENTRY: assert property (s_fall |=> power_down_o)
      else $error("no power-down after cke fell");
   AST_EXIT: assert property (s_wake |=> !power_down_o && pd_kind_o == pdc_pkg::PD_NONE)
      else $error("no wake-up after exit latency");
   AST_RX_OFF: assert property ($rose(power_down_o) |-> rx_enable_o ##1 !rx_enable_o)
      else $error("receivers not off one cycle after entry");
   AST_RX_AWAKE: assert property (!power_down_o |-> rx_enable_o)
      else $error("receivers off while awake");
   AST_IGNORE: assert property (req && power_down_o |=> cmd_reject_o && !cmd_exec_o)
      else $error("command taken in power-down");
   AST_ONE_ANSWER: assert property (req |=> cmd_exec_o != cmd_reject_o)
      else $error("command not answered once");
   AST_LOW_PWR: assert property (low_power_o |-> !rx_enable_o && !array_busy_i)
      else $error("low current before array finished");
   AST_KIND_HOLD: assert property (power_down_o && $past(power_down_o) |-> $stable(pd_kind_o))
      else $error("variant changed in power-down");
   AST_KIND_SET: assert property (power_down_o |-> pd_kind_o != pdc_pkg::PD_NONE)
      else $error("no variant in power-down");
   AST_SR_SELF: assert property (sr_refresh_o && power_down_o |-> pd_kind_o == pdc_pkg::PD_SELF)
      else $error("refresh in non-self power-down");
   AST_ODT_OFF: assert property (!vddq_ok_i |-> !ca_odt_o)
      else $error("termination without supply");
   AST_ODT_KEEP: assert property (ca_odt_o && !we_i |=> ca_odt_o || !vddq_ok_i)
      else $error("termination dropped");
endmodule // pdc_pd_chk

bind pdc_power_down pdc_pd_chk u_chk (.clk_sys_i, .reset_i, .cke_i, .vddq_ok_i, .array_busy_i,
   .cmd_valid_i, .cmd_i, .we_i, .cmd_exec_o, .cmd_reject_o, .rx_enable_o, .power_down_o,
   .low_power_o, .pd_kind_o, .sr_refresh_o, .ca_odt_o);

/* pdc_ctrl_model.sv */
// Memory-controller model driving CKE and decoded commands.
// Assumes the bench calls its tasks; clock runs free from the bench.
`timescale 1ns/1ps

module pdc_ctrl_model #(
   parameter int GUARD_CYC   = 3, // Spacing before CKE may fall
   parameter int CKE_MIN_CYC = 4  // Least CKE low or high time
) (
   input wire logic             clk_sys_i,   // Core clock
   output logic                 cke_o,       // Clock enable to device
   output logic                 cmd_valid_o, // Command present
   output pdc_pkg::pdc_cmd_type cmd_o        // Command lines
);
   initial begin
      cke_o = 1'b1;
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One command for one cycle; released lines show garbage, not the last value
   task automatic send(input pdc_pkg::pdc_cmd_kind_type k, input logic [5:0] a);
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b1;
      cmd_o <= '{kind: k, bank: 3'h1, auto_pre: 1'b0, mr_addr: a};
      @(posedge clk_sys_i);
      cmd_valid_o <= 1'b0;
      cmd_o <= pdc_pkg::pdc_cmd_type'(~cmd_o);
   endtask

   // Guard covers command-to-CKE spacing; no burst or oscillator is left running
   task automatic pd_enter;
      repeat (GUARD_CYC) @(posedge clk_sys_i);
      cke_o <= 1'b0;
      repeat (CKE_MIN_CYC) @(posedge clk_sys_i);
   endtask

   // Clock never stops here, so it is stable before CKE rises
   task automatic pd_exit;
      @(posedge clk_sys_i);
      cke_o <= 1'b1;
      repeat (CKE_MIN_CYC) @(posedge clk_sys_i);
   endtask
endmodule // pdc_ctrl_model

/* tb_dram_power_down_control.sv */
// Self-checking bench for the power-down block and its controller model.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps

module tb_dram_power_down_control;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, vddq_ok_i = 1'b1, array_busy_i = 1'b0;
   logic we_i = 1'b0, re_i = 1'b0, cke_i, cmd_valid_i;
   logic cmd_exec_o, cmd_reject_o, rx_enable_o, power_down_o, low_power_o;
   logic sr_refresh_o, zq_busy_o, ca_odt_o;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, rv;
   pdc_pkg::pdc_cmd_type cmd_i, cmd_exec_cmd_o;
   pdc_pkg::pdc_pd_kind_type pd_kind_o;
   int errors = 0, n_tests = 0, c;

   always #10 clk_sys_i = ~clk_sys_i;

   pdc_power_down DUT (.clk_sys_i, .reset_i, .cke_i, .vddq_ok_i, .array_busy_i, .cmd_valid_i,
      .cmd_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .cmd_exec_o, .cmd_exec_cmd_o,
      .cmd_reject_o, .rx_enable_o, .power_down_o, .low_power_o, .pd_kind_o, .sr_refresh_o,
      .zq_busy_o, .ca_odt_o);
   pdc_ctrl_model CTRL (.clk_sys_i, .cke_o(cke_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      we_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      re_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Answer is registered on the taking edge and read 1 ns later
   task automatic cmd(input pdc_pkg::pdc_cmd_kind_type k, input logic [5:0] a, input logic ex);
      CTRL.send(k, a);
      #1 chk(cmd_exec_o === ex && cmd_reject_o === !ex && (!ex || cmd_exec_cmd_o.kind === k),
         "command answer");
   endtask
   task automatic count_sr(input int n);
      c = 0;
      repeat (n) begin
         @(posedge clk_sys_i);
         #1 if (sr_refresh_o === 1'b1) c++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs;
      rd(pdc_pkg::REG_STATUS, rv);
      chk(rv === 32'h10 && pd_kind_o === pdc_pkg::PD_NONE, "status after reset");
      rd(4'h8, rv);
      chk(rv === 32'h0, "unmapped read");
      wr(pdc_pkg::REG_CTRL, 32'h50);
      #1 chk(ca_odt_o === 1'b1, "termination on");
      $display("test regs done");
   endtask
   task automatic t_idle;
      CTRL.pd_enter();
      #1 chk(pd_kind_o === pdc_pkg::PD_IDLE && rx_enable_o === 1'b0, "idle entry");
      cmd(pdc_pkg::CMD_ACT, 6'h00, 1'b0);
      count_sr(250);
      chk(c == 0 && ca_odt_o === 1'b1, "no refresh, termination kept");
      @(posedge clk_sys_i);
      vddq_ok_i <= 1'b0;
      #1 chk(ca_odt_o === 1'b0, "termination needs supply");
      @(posedge clk_sys_i);
      vddq_ok_i <= 1'b1;
      CTRL.pd_exit();
      #1 chk(power_down_o === 1'b0 && pd_kind_o === pdc_pkg::PD_NONE, "exit");
      cmd(pdc_pkg::CMD_MRR, 6'h05, 1'b1);
      $display("test idle done");
   endtask
   task automatic t_active;
      cmd(pdc_pkg::CMD_ACT, 6'h00, 1'b1);
      @(posedge clk_sys_i);
      array_busy_i <= 1'b1;
      CTRL.pd_enter();
      #1 chk(pd_kind_o === pdc_pkg::PD_ACTIVE && low_power_o === 1'b0, "active entry");
      @(posedge clk_sys_i);
      array_busy_i <= 1'b0;
      #1 chk(low_power_o === 1'b1, "low current after array done");
      CTRL.pd_exit();
      cmd(pdc_pkg::CMD_PREA, 6'h00, 1'b1);
      $display("test active done");
   endtask
   task automatic t_self;
      cmd(pdc_pkg::CMD_SRE, 6'h00, 1'b1);
      CTRL.pd_enter();
      #1 chk(pd_kind_o === pdc_pkg::PD_SELF, "self entry");
      count_sr(400);
      chk(c >= 2 && c <= 3, "refresh continues");
      CTRL.pd_exit();
      $display("test self done");
   endtask
   task automatic t_xsr;
      logic [5:0] mra [3];
      mra = '{pdc_pkg::MRA_SR_ABORT, pdc_pkg::MRA_PASR_BANK, pdc_pkg::MRA_PASR_SEG};
      foreach (mra[i]) begin
         cmd(pdc_pkg::CMD_SRE, 6'h00, 1'b1);
         cmd(pdc_pkg::CMD_SRX, 6'h00, 1'b1);
         cmd(pdc_pkg::CMD_MRW, mra[i], 1'b0);
         cmd(pdc_pkg::CMD_MRW, 6'h20, 1'b1);
         cmd(i == 0 ? pdc_pkg::CMD_MRR : pdc_pkg::CMD_MPC, 6'h01, 1'b1);
         cmd(pdc_pkg::CMD_ACT, 6'h00, 1'b0);
         repeat (12) @(posedge clk_sys_i);
      end
      cmd(pdc_pkg::CMD_ACT, 6'h00, 1'b1);
      cmd(pdc_pkg::CMD_PREA, 6'h00, 1'b1);
      $display("test xsr done");
   endtask
   task automatic t_refresh;
      pdc_pkg::pdc_cmd_kind_type k [2];
      k = '{pdc_pkg::CMD_REFAB, pdc_pkg::CMD_REFPB};
      foreach (k[i]) begin
         cmd(k[i], 6'h00, 1'b1);
         cmd(k[i], 6'h00, 1'b0);
         cmd(pdc_pkg::CMD_MRR, 6'h02, 1'b1);
         cmd(pdc_pkg::CMD_MRW, 6'h04, 1'b1);
         cmd(pdc_pkg::CMD_MPC, 6'h03, 1'b1);
         repeat (10) @(posedge clk_sys_i);
      end
      $display("test refresh done");
   endtask
   task automatic t_zq;
      cmd(pdc_pkg::CMD_ZQS, 6'h00, 1'b1);
      repeat (3) @(posedge clk_sys_i);
      CTRL.pd_enter();
      #1 chk(zq_busy_o === 1'b1 && power_down_o === 1'b1, "calibration in power-down");
      CTRL.pd_exit();
      $display("test zq done");
   endtask

   initial begin
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_regs();
      t_idle();
      t_active();
      t_self();
      t_xsr();
      t_refresh();
      t_zq();
      print_verdict();
   end
endmodule // tb_dram_power_down_control
